// ### inc/lfm_pkg.sv
// Shared constants and types for the LED frame memory section select block.
package lfm_pkg;
  // Section pointer location and the section codes written to it.
  localparam logic [7:0] LFM_PTR_ADDR = 8'hFD;
  localparam logic [7:0] LFM_NO_OPERATION_CODE = 8'h00;
  localparam logic [7:0] LFM_FRAME_FIRST = 8'h01;
  localparam logic [7:0] LFM_FRAME_LAST = 8'h24;
  localparam logic [7:0] LFM_PWM_FIRST = 8'h40;
  localparam logic [7:0] LFM_PWM_LAST = 8'h45;
  localparam logic [7:0] LFM_DOTCORR_CODE = 8'h80;
  localparam logic [7:0] LFM_CTRL_CODE = 8'hC0;
  localparam logic [7:0] LFM_PTR_RESET = 8'h00;
  // Configuration register inside the control section.
  localparam logic [7:0] LFM_CFG_ADDR = 8'h06;
  localparam int LFM_CFG_CONF_LSB = 0;
  localparam int LFM_CFG_DC_BIT = 4;
  localparam logic [2:0] LFM_CONF_MIN = 3'h1;
  localparam logic [2:0] LFM_CONF_MAX = 3'h6;
  localparam logic [2:0] LFM_CONF_RESET = 3'h1;
  localparam logic LFM_DC_RESET = 1'b0;
  // Frame count for a configuration is BASE - STEP * conf - dot correction.
  localparam logic [5:0] LFM_FRAMES_BASE = 6'h2A;
  localparam logic [5:0] LFM_FRAMES_STEP = 6'h06;
  // Matrix geometry and frame layout.
  localparam int LFM_NUM_FRAMES = 36;
  localparam int LFM_NUM_SEGS = 12;
  localparam int LFM_LEDS_PER_SEG = 11;
  localparam int LFM_NUM_LEDS = 132;
  localparam logic [7:0] LFM_FRAME_BYTES = 8'h18;
  localparam int LFM_LO_LEDS = 8;
  localparam int LFM_HI_LEDS = 3;
  localparam int LFM_SET_LSB = 5;
  localparam int LFM_SET_W = 3;
  // Kind of the selected section, Gray coded along the code order.
  typedef enum logic [2:0] {
    LFM_SEC_NONE = 3'b000,
    LFM_SEC_FRAME = 3'b001,
    LFM_SEC_PWM = 3'b011,
    LFM_SEC_DOTCORR = 3'b010,
    LFM_SEC_CTRL = 3'b110
  } lfm_sec_t;
endpackage

// ### rtl/lfm_sec_decode.sv
// Decoder from a section code byte to a section kind and index.
`timescale 1ns/1ps
module lfm_sec_decode (
  // Code byte.
  input wire logic [7:0] code,
  // Decoded section.
  output logic valid,
  output lfm_pkg::lfm_sec_t kind,
  output logic [5:0] index
);
  // Purely combinational; codes outside the table report not valid.
  always_comb begin
    valid = 1'b1;
    kind = lfm_pkg::LFM_SEC_NONE;
    index = 6'h00;
    if (code >= lfm_pkg::LFM_FRAME_FIRST && code <= lfm_pkg::LFM_FRAME_LAST) begin
      kind = lfm_pkg::LFM_SEC_FRAME;
      index = 6'(code - lfm_pkg::LFM_FRAME_FIRST);
    end else if (code >= lfm_pkg::LFM_PWM_FIRST && code <= lfm_pkg::LFM_PWM_LAST) begin
      kind = lfm_pkg::LFM_SEC_PWM;
      index = 6'(code - lfm_pkg::LFM_PWM_FIRST);
    end else if (code == lfm_pkg::LFM_DOTCORR_CODE) begin
      kind = lfm_pkg::LFM_SEC_DOTCORR;
    end else if (code == lfm_pkg::LFM_CTRL_CODE) begin
      kind = lfm_pkg::LFM_SEC_CTRL;
    end else begin
      // The no-operation code and unknown codes change nothing.
      valid = 1'b0;
    end
  end
endmodule

// ### rtl/lfm_frame_mem.sv
// Section pointer, RAM configuration lock and On/Off frame storage.
//
// Notes on behaviour
// - Pointer at FD selects target section.
// - Selected section holds until another is written.
// - Codes 01 to 24 select frames 0-35.
// - 00 nothing; 40-45 sets; 80 dot; C0 control.
// - Shown frame combines On/Off and set data.
// - Each frame names its set; device applies it.
// - Six configurations trade sets and dot correction.
// - First frame write locks configuration until reset.
// - LED bits reset dark; one lights LED.
// - Eleven LEDs per segment in two bytes.
// - Segment zero byte 01 carries set index.
// - One twelve by eleven matrix.
// - Address byte is read within current section.
`timescale 1ns/1ps
module lfm_frame_mem (
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Register write port from the serial front end.
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Register read port.
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Current section.
  output lfm_pkg::lfm_sec_t section_kind,
  output logic [5:0] section_index,
  // RAM configuration state.
  output logic [2:0] config_mode,
  output logic dot_corr_en,
  output logic config_locked,
  // Writes forwarded to set, dot correction and control sections.
  output logic ext_wr_valid,
  output lfm_pkg::lfm_sec_t ext_wr_kind,
  output logic [5:0] ext_wr_index,
  output logic [7:0] ext_wr_addr,
  output logic [7:0] ext_wr_data,
  // Display fetch.
  input wire logic [5:0] disp_frame,
  output logic [131:0] disp_leds,
  output logic [2:0] disp_set
);
  // Raw pointer byte as last accepted.
  logic [7:0] sec_ptr;
  logic [7:0] next_sec_ptr;
  lfm_pkg::lfm_sec_t next_section_kind;
  logic [5:0] next_section_index;
  // Decoder results for the incoming data byte.
  logic dec_valid;
  lfm_pkg::lfm_sec_t dec_kind;
  logic [5:0] dec_index;
  // Configuration next values.
  logic [2:0] next_config_mode;
  logic next_dot_corr_en;
  logic next_config_locked;
  // Frame store: one flat 132-bit vector per frame plus its set index.
  logic [131:0] led_mem [lfm_pkg::LFM_NUM_FRAMES];
  logic [2:0] set_mem [lfm_pkg::LFM_NUM_FRAMES];
  // Frame write request computed combinationally.
  logic mem_we;
  logic [5:0] mem_idx;
  logic [3:0] mem_seg;
  logic mem_hi;
  // Frames available in the present configuration.
  logic [5:0] frame_limit;
  // Other next values.
  logic [7:0] next_rd_data;
  logic next_ext_wr_valid;
  logic [131:0] next_disp_leds;
  logic [2:0] next_disp_set;
  // Whether a write addresses the pointer or the configuration register.
  logic ptr_wr;
  logic cfg_wr;

  lfm_sec_decode u_dec (
    .code(wr_data),
    .valid(dec_valid),
    .kind(dec_kind),
    .index(dec_index)
  );

  // Each extra set costs six frames, dot correction one more.
  // Configuration one with no dot correction keeps all thirty-six frames.
  assign frame_limit = 6'(lfm_pkg::LFM_FRAMES_BASE - lfm_pkg::LFM_FRAMES_STEP * config_mode
    - {5'h00, dot_corr_en});

  assign ptr_wr = wr_en && wr_addr == lfm_pkg::LFM_PTR_ADDR;
  assign cfg_wr = wr_en && !ptr_wr && section_kind == lfm_pkg::LFM_SEC_CTRL
    && wr_addr == lfm_pkg::LFM_CFG_ADDR;

  // Pointer next values: only a valid code moves it.
  // The pointer is a plain register, so a burst of writes never walks into the next section.
  always_comb begin
    next_sec_ptr = sec_ptr;
    next_section_kind = section_kind;
    next_section_index = section_index;
    if (ptr_wr && dec_valid) begin
      next_sec_ptr = wr_data;
      next_section_kind = dec_kind;
      next_section_index = dec_index;
    end
    // Otherwise the old section stays in force.
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sec_ptr <= lfm_pkg::LFM_PTR_RESET;
      section_kind <= lfm_pkg::LFM_SEC_NONE;
      section_index <= 6'h00;
    end else begin
      sec_ptr <= next_sec_ptr;
      section_kind <= next_section_kind;
      section_index <= next_section_index;
    end
  end

  // Frame write decode: address is taken within the selected frame.
  // A write to a frame that the configuration cannot hold is dropped here, so it neither
  // lands in storage nor locks the configuration; bytes past the last segment drop too.
  always_comb begin
    mem_we = 1'b0;
    mem_idx = section_index;
    mem_seg = wr_addr[4:1];
    mem_hi = wr_addr[0];
    if (wr_en && !ptr_wr && section_kind == lfm_pkg::LFM_SEC_FRAME
        && section_index < frame_limit && wr_addr < lfm_pkg::LFM_FRAME_BYTES) begin
      mem_we = 1'b1;
    end
  end

  // Configuration: changes are refused once any frame was written.
  always_comb begin
    next_config_mode = config_mode;
    next_dot_corr_en = dot_corr_en;
    next_config_locked = config_locked || mem_we;
    if (cfg_wr && !config_locked) begin
      // The host is trusted to do this before loading frames.
      if (wr_data[2:0] >= lfm_pkg::LFM_CONF_MIN && wr_data[2:0] <= lfm_pkg::LFM_CONF_MAX) begin
        next_config_mode = wr_data[lfm_pkg::LFM_CFG_CONF_LSB +: 3];
      end
      next_dot_corr_en = wr_data[lfm_pkg::LFM_CFG_DC_BIT];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      config_mode <= lfm_pkg::LFM_CONF_RESET;
      dot_corr_en <= lfm_pkg::LFM_DC_RESET;
      config_locked <= 1'b0;
    end else begin
      config_mode <= next_config_mode;
      dot_corr_en <= next_dot_corr_en;
      config_locked <= next_config_locked;
    end
  end

  // Frame store: every LED starts dark; segment zero's high byte also holds the set.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int f = 0; f < lfm_pkg::LFM_NUM_FRAMES; f++) begin
        led_mem[f] <= '0;
        set_mem[f] <= 3'h0;
      end
    end else if (mem_we) begin
      if (!mem_hi) begin
        led_mem[mem_idx][int'(mem_seg) * lfm_pkg::LFM_LEDS_PER_SEG +: lfm_pkg::LFM_LO_LEDS]
          <= wr_data;
      end else begin
        led_mem[mem_idx][int'(mem_seg) * lfm_pkg::LFM_LEDS_PER_SEG + lfm_pkg::LFM_LO_LEDS
          +: lfm_pkg::LFM_HI_LEDS] <= wr_data[2:0];
        if (mem_seg == 4'h0) begin
          set_mem[mem_idx] <= wr_data[lfm_pkg::LFM_SET_LSB +: lfm_pkg::LFM_SET_W];
        end
      end
    end
  end

  // Read data: unmapped bytes and don't-care bits read as zero.
  always_comb begin
    next_rd_data = 8'h00;
    if (rd_addr == lfm_pkg::LFM_PTR_ADDR) begin
      next_rd_data = sec_ptr;
    end else if (section_kind == lfm_pkg::LFM_SEC_CTRL && rd_addr == lfm_pkg::LFM_CFG_ADDR) begin
      next_rd_data = {3'h0, dot_corr_en, 1'b0, config_mode};
    end else if (section_kind == lfm_pkg::LFM_SEC_FRAME
                 && rd_addr < lfm_pkg::LFM_FRAME_BYTES) begin
      if (!rd_addr[0]) begin
        next_rd_data = led_mem[section_index][int'(rd_addr[4:1]) * lfm_pkg::LFM_LEDS_PER_SEG
          +: lfm_pkg::LFM_LO_LEDS];
      end else begin
        next_rd_data[2:0] = led_mem[section_index][int'(rd_addr[4:1])
          * lfm_pkg::LFM_LEDS_PER_SEG + lfm_pkg::LFM_LO_LEDS +: lfm_pkg::LFM_HI_LEDS];
        if (rd_addr[4:1] == 4'h0) begin
          next_rd_data[7:5] = set_mem[section_index];
        end
      end
    end
  end

  // Forward writes aimed at sections that live in other blocks.
  assign next_ext_wr_valid = wr_en && !ptr_wr && (section_kind == lfm_pkg::LFM_SEC_PWM
    || section_kind == lfm_pkg::LFM_SEC_DOTCORR || section_kind == lfm_pkg::LFM_SEC_CTRL);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      ext_wr_valid <= 1'b0;
      ext_wr_kind <= lfm_pkg::LFM_SEC_NONE;
      ext_wr_index <= 6'h00;
      ext_wr_addr <= 8'h00;
      ext_wr_data <= 8'h00;
    end else begin
      rd_data <= rd_en ? next_rd_data : rd_data;
      rd_valid <= rd_en;
      ext_wr_valid <= next_ext_wr_valid;
      ext_wr_kind <= section_kind;
      ext_wr_index <= section_index;
      ext_wr_addr <= wr_addr;
      ext_wr_data <= wr_data;
    end
  end

  // Display fetch: a frame beyond the configured count shows dark.
  // The count follows the live configuration, so such a frame goes dark on the next clock edge
  // instead of showing bits left over from an earlier layout.
  always_comb begin
    next_disp_leds = '0;
    next_disp_set = 3'h0;
    if (disp_frame < frame_limit) begin
      next_disp_leds = led_mem[disp_frame];
      next_disp_set = set_mem[disp_frame];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      disp_leds <= '0;
      disp_set <= 3'h0;
    end else begin
      disp_leds <= next_disp_leds;
      disp_set <= next_disp_set;
    end
  end

  // Checks on the logic above.
  a_ptr_update: assert property (@(posedge mclk) disable iff (!resetn)
    ptr_wr && dec_valid |=> sec_ptr == $past(wr_data) && section_kind == $past(dec_kind))
    else $error("pointer did not take valid code");
  a_ptr_hold: assert property (@(posedge mclk) disable iff (!resetn)
    !ptr_wr |=> $stable(section_kind) && $stable(section_index))
    else $error("section changed without pointer write");
  a_bad_code_kept: assert property (@(posedge mclk) disable iff (!resetn)
    ptr_wr && !dec_valid |=> $stable(sec_ptr))
    else $error("invalid code moved pointer");
  a_frame_code_map: assert property (@(posedge mclk) disable iff (!resetn)
    sec_ptr >= 8'h01 && sec_ptr <= 8'h24 |-> section_kind == lfm_pkg::LFM_SEC_FRAME
      && {2'h0, section_index} == sec_ptr - 8'h01)
    else $error("frame code mapped wrong");
  a_ctrl_code_map: assert property (@(posedge mclk) disable iff (!resetn)
    sec_ptr == 8'hC0 |-> section_kind == lfm_pkg::LFM_SEC_CTRL)
    else $error("control code mapped wrong");
  a_cfg_locked_hold: assert property (@(posedge mclk) disable iff (!resetn)
    config_locked |=> config_locked && $stable(config_mode) && $stable(dot_corr_en))
    else $error("locked configuration changed");
  a_lock_on_write: assert property (@(posedge mclk) disable iff (!resetn)
    mem_we |=> config_locked)
    else $error("frame write did not lock");
  a_conf_range: assert property (@(posedge mclk) disable iff (!resetn)
    config_mode >= 3'h1 && config_mode <= 3'h6 && frame_limit <= 6'h24)
    else $error("configuration out of range");
  a_disp_dark: assert property (@(posedge mclk) disable iff (!resetn)
    disp_frame >= frame_limit |=> disp_leds == '0 && disp_set == 3'h0)
    else $error("missing frame not dark");
  a_rd_answer: assert property (@(posedge mclk) disable iff (!resetn)
    rd_en && rd_addr == 8'hFD |=> rd_valid && rd_data == $past(sec_ptr))
    else $error("pointer read wrong");
  // Forwarded control-section writes and the read strobe follow their request by exactly one cycle.
  a_ext_forward: assert property (@(posedge mclk) disable iff (!resetn)
    wr_en && !ptr_wr && section_kind == lfm_pkg::LFM_SEC_CTRL |=> ext_wr_valid
      && ext_wr_addr == $past(wr_addr) && ext_wr_data == $past(wr_data))
    else $error("control write not forwarded");
  a_rd_strobe: assert property (@(posedge mclk) disable iff (!resetn)
    rd_en |=> rd_valid)
    else $error("read strobe not answered");
  a_dc_taken: assert property (@(posedge mclk) disable iff (!resetn)
    cfg_wr && !config_locked |=> dot_corr_en == $past(wr_data[lfm_pkg::LFM_CFG_DC_BIT]))
    else $error("dot correction bit not taken");
  c_frame_select: cover property (@(posedge mclk) disable iff (!resetn)
    ptr_wr && dec_kind == lfm_pkg::LFM_SEC_FRAME ##[1:2] mem_we);
  c_dark_beyond_limit: cover property (@(posedge mclk) disable iff (!resetn)
    disp_frame >= frame_limit ##1 disp_leds == '0);
  c_locked_cfg_try: cover property (@(posedge mclk) disable iff (!resetn)
    cfg_wr && config_locked);
  c_ext_write: cover property (@(posedge mclk) disable iff (!resetn) ext_wr_valid);
endmodule

// ### sim/lfm_host.sv
// Host model that issues register writes and reads toward the frame memory block.
`timescale 1ns/1ps
module lfm_host (
  // Clock.
  input wire logic mclk,
  // Register port toward the device.
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic rd_en,
  output logic [7:0] rd_addr
);
  // Strobes idle low from time zero, so nothing is taken during reset.
  initial begin
    wr_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    rd_en = 1'b0;
    rd_addr = 8'h00;
  end
  // One byte write: the address byte travels with its data byte over one edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge mclk);
    wr_en = 1'b0;
    // A released bus shows the inverse, so a stale byte can never look valid.
    wr_addr = ~a;
    wr_data = ~d;
  endtask
  // One byte read; the caller samples the answer when this returns.
  task automatic rd(input logic [7:0] a);
    @(negedge mclk);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge mclk);
    rd_en = 1'b0;
    rd_addr = ~a;
  endtask
endmodule

// ### sim/led_frame_memory_section_select_tb_top.sv
// Self-checking bench comparing the frame memory block with a behavioural model.
`timescale 1ns/1ps
module led_frame_memory_section_select_tb_top;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic wr_en, rd_en, rd_valid, dot_corr_en, config_locked, ext_wr_valid;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data, ext_wr_addr, ext_wr_data;
  logic [5:0] section_index, ext_wr_index;
  logic [5:0] disp_frame = 6'h00;
  logic [2:0] config_mode, disp_set;
  logic [131:0] disp_leds;
  lfm_pkg::lfm_sec_t section_kind, ext_wr_kind;
  // Model state, kept apart from anything the design computes.
  lfm_pkg::lfm_sec_t m_kind;
  logic [5:0] m_idx;
  logic [7:0] m_code;
  logic [2:0] m_conf;
  logic m_dc, m_lock;
  logic [7:0] mem [36][24];
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 32'h70a3;
  // Clock at 100 MHz.
  initial begin
    forever #5 mclk = ~mclk;
  end
  lfm_host u_host (.mclk(mclk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr));
  lfm_frame_mem u_dut (.mclk(mclk), .resetn(resetn), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .section_kind(section_kind), .section_index(section_index),
    .config_mode(config_mode), .dot_corr_en(dot_corr_en), .config_locked(config_locked),
    .ext_wr_valid(ext_wr_valid), .ext_wr_kind(ext_wr_kind), .ext_wr_index(ext_wr_index),
    .ext_wr_addr(ext_wr_addr), .ext_wr_data(ext_wr_data), .disp_frame(disp_frame),
    .disp_leds(disp_leds), .disp_set(disp_set));
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // A hang is cut short well beyond the expected run length.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      tally_and_finish();
    end
  end
  // Case-equality compare; an X or Z bit matches only the same X or Z in the expected value.
  task automatic chk(input logic [131:0] s, input logic [131:0] e);
    n_checks = n_checks + 1;
    if (s !== e) begin
      bad_count = bad_count + 1;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Number of frames that the current configuration can store.
  function automatic int lim();
    return 42 - 6 * int'(m_conf) - int'(m_dc);
  endfunction
  // Bits of a frame byte that carry state; the rest read back as zero.
  function automatic logic [7:0] msk(input logic [7:0] a);
    return a[0] ? ((a == 8'h01) ? 8'hE7 : 8'h07) : 8'hFF;
  endfunction
  // Writes one byte through the host, updates the model and compares.
  task automatic wr_chk(input logic [7:0] a, input logic [7:0] d);
    logic ext;
    ext = 1'b0;
    // Unknown codes and the no-operation code leave the pointer alone.
    if (a == lfm_pkg::LFM_PTR_ADDR) begin
      if (d >= 8'h01 && d <= 8'h24) begin
        m_code = d;
        m_kind = lfm_pkg::LFM_SEC_FRAME;
        m_idx = 6'(d - 8'h01);
      end else if (d >= 8'h40 && d <= 8'h45) begin
        m_code = d;
        m_kind = lfm_pkg::LFM_SEC_PWM;
        m_idx = 6'(d - 8'h40);
      end else if (d == 8'h80 || d == 8'hC0) begin
        m_code = d;
        m_kind = (d == 8'h80) ? lfm_pkg::LFM_SEC_DOTCORR : lfm_pkg::LFM_SEC_CTRL;
        m_idx = 6'h00;
      end
    end else if (m_kind == lfm_pkg::LFM_SEC_FRAME) begin
      if (a < 8'h18 && int'(m_idx) < lim()) begin
        mem[m_idx][a] = d & msk(a);
        m_lock = 1'b1;
      end
    end else if (m_kind != lfm_pkg::LFM_SEC_NONE) begin
      ext = 1'b1;
      if (m_kind == lfm_pkg::LFM_SEC_CTRL && a == 8'h06 && !m_lock) begin
        if (d[2:0] >= 3'h1 && d[2:0] <= 3'h6) begin
          m_conf = d[2:0];
        end
        m_dc = d[4];
      end
    end
    u_host.wr(a, d);
    chk(8'(section_kind), 8'(m_kind));
    chk(section_index, m_idx);
    chk(config_mode, m_conf);
    chk(dot_corr_en, m_dc);
    chk(config_locked, m_lock);
    chk(ext_wr_valid, ext);
    if (ext) begin
      chk({8'(ext_wr_kind), ext_wr_index, ext_wr_addr, ext_wr_data},
        {8'(m_kind), m_idx, a, d});
    end
  endtask
  // Reads one byte and compares it with the model.
  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] e;
    e = 8'h00;
    if (a == lfm_pkg::LFM_PTR_ADDR) begin
      e = m_code;
    end else if (m_kind == lfm_pkg::LFM_SEC_CTRL && a == 8'h06) begin
      e = {3'h0, m_dc, 1'b0, m_conf};
    end else if (m_kind == lfm_pkg::LFM_SEC_FRAME && a < 8'h18 && int'(m_idx) < lim()) begin
      e = mem[m_idx][a];
    end
    u_host.rd(a);
    chk(rd_valid, 1'b1);
    chk(rd_data, e);
  endtask
  // Shows one frame and compares the fetched LED bits and set index.
  task automatic disp_chk(input logic [5:0] f);
    logic [131:0] e;
    logic [2:0] s;
    e = '0;
    s = 3'h0;
    if (int'(f) < lim()) begin
      for (int g = 0; g < 12; g++) begin
        for (int l = 0; l < 11; l++) begin
          e[g * 11 + l] = (l < 8) ? mem[f][2 * g][l] : mem[f][2 * g + 1][l - 8];
        end
      end
      s = mem[f][1][7:5];
    end
    @(negedge mclk);
    disp_frame = f;
    @(negedge mclk);
    chk(disp_leds, e);
    chk(disp_set, s);
  endtask
  // Main sequence: reset, configuration, every code, frame traffic, lock.
  initial begin
    logic [5:0] f;
    logic [7:0] a;
    foreach (mem[i, j]) mem[i][j] = 8'h00;
    m_kind = lfm_pkg::LFM_SEC_NONE;
    m_idx = 6'h00;
    m_code = 8'h00;
    m_conf = 3'h1;
    m_dc = 1'b0;
    m_lock = 1'b0;
    repeat (8) @(negedge mclk);
    resetn = 1'b1;
    chk(8'(section_kind), 8'(lfm_pkg::LFM_SEC_NONE));
    chk({config_mode, config_locked}, {3'h1, 1'b0});
    disp_chk(6'h00);
    wr_chk(8'hFD, 8'hC0);
    wr_chk(8'h06, 8'h07);
    wr_chk(8'h06, 8'h13);
    for (int c = 0; c < 256; c++) begin
      wr_chk(8'hFD, 8'(c));
      rd_chk(8'hFD);
      if (m_kind != lfm_pkg::LFM_SEC_FRAME && m_kind != lfm_pkg::LFM_SEC_NONE) begin
        wr_chk(8'h03, 8'($random(seed)));
      end
    end
    for (int n = 0; n < 40; n++) begin
      f = (n < 2) ? 6'(lim() - 1 + n) : 6'(($random(seed) & 63) % 36);
      a = (n < 2) ? 8'h01 : 8'(($random(seed) & 31));
      wr_chk(8'hFD, 8'(f) + 8'h01);
      wr_chk(a, 8'($random(seed)));
      if (a < 8'h18) begin
        rd_chk(a);
      end
      disp_chk(f);
    end
    wr_chk(8'hFD, 8'hC0);
    wr_chk(8'h06, 8'h01);
    rd_chk(8'h06);
    // A second reset must open the lock again and clear frame zero, the only frame checked.
    @(negedge mclk);
    resetn = 1'b0;
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    foreach (mem[i, j]) mem[i][j] = 8'h00;
    m_kind = lfm_pkg::LFM_SEC_NONE;
    m_idx = 6'h00;
    m_code = 8'h00;
    m_conf = 3'h1;
    m_dc = 1'b0;
    m_lock = 1'b0;
    chk({config_mode, config_locked}, {3'h1, 1'b0});
    wr_chk(8'hFD, 8'hC0);
    wr_chk(8'h06, 8'h02);
    rd_chk(8'h06);
    wr_chk(8'hFD, 8'h01);
    wr_chk(8'h00, 8'($random(seed)));
    disp_chk(6'h00);
    tally_and_finish();
  end
endmodule
